// ==== qa_wdg_pkg.sv ====
package qa_wdg_pkg;

  // Slow watchdog timebase derived from mclk
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned TICK_PERIOD_NS = 15625;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [10:0] TICK_LAST      = 11'(TICK_CYCLES - 1);

  // Counter values
  localparam logic [2:0] FAULT_INIT   = 3'h6;
  localparam logic [2:0] ALARM_ABOVE  = 3'h4;
  localparam logic [2:0] TALLY_MAX    = 3'h7;
  localparam logic [1:0] INDEX_INIT   = 2'h3;
  localparam logic [1:0] INDEX_LAST   = 2'h0;
  localparam logic [3:0] SEQ_WRAP     = 4'hF;
  localparam logic [3:0] SEQ_INIT     = 4'h0;

  // Field positions of the question high register
  localparam int unsigned QH_VALUE_BIT = 0;
  localparam int unsigned QH_LATE_BIT  = 1;
  localparam int unsigned QH_FAULT_LSB = 4;

  typedef enum logic [1:0] {
    PH_WAIT = 2'b00,
    PH_WIN  = 2'b01
  } phase_t;

endpackage

// ==== qa_link_if.sv ====
`timescale 1ns/10ps
interface qa_link_if;
  logic       advance;
  logic [3:0] question;

  modport ctl (output advance, input question);
  modport gen (input advance, output question);
endinterface

// ==== slow_tick_gen.sv ====
`timescale 1ns/10ps
module slow_tick_gen (
  input  wire logic mclk,
  input  wire logic resetn,
  output logic      slow_tick
);

  typedef struct packed {
    logic [10:0] count;
    logic        tick;
  } tick_st_t;

  tick_st_t s_q;
  tick_st_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (s_q.count == qa_wdg_pkg::TICK_LAST) begin
      s_d.count = 11'h000;
      s_d.tick  = 1'b1;
    end else begin
      s_d.count = s_q.count + 11'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign slow_tick = s_q.tick;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  tick_period_a: assert property (s_q.tick |=> !s_q.tick [*2])
    else $error("slow tick repeated too soon");

endmodule

// ==== question_gen.sv ====
`timescale 1ns/10ps
module question_gen (
  input  wire logic mclk,
  input  wire logic resetn,
  qa_link_if.gen    lk
);

  typedef struct packed {
    logic [3:0] count;
    logic [3:0] chain;
    logic [3:0] question;
  } gen_st_t;

  gen_st_t s_q;
  gen_st_t s_d;
  logic    feedback;

  always_comb begin
    s_d = s_q;
    feedback = (s_q.chain[3] ^ s_q.chain[2]) ^ ~|s_q.chain;
    if (lk.advance) begin
      s_d.count = s_q.count + 4'h1;
      if (s_q.count == qa_wdg_pkg::SEQ_WRAP) begin
        s_d.chain = {s_q.chain[2:0], feedback};
      end
    end
    s_d.question = {s_d.chain[2] ^ s_d.count[2], s_d.chain[0] ^ s_d.count[0],
                    s_d.chain[3] ^ s_d.count[3], s_d.chain[1] ^ s_d.count[1]};
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign lk.question = s_q.question;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  question_hold_a: assert property (!lk.advance |=> $stable(s_q.count) && $stable(s_q.chain))
    else $error("question changed without advance");
  zero_exit_a: assert property (lk.advance && s_q.count == qa_wdg_pkg::SEQ_WRAP
                                && s_q.chain == 4'h0 |=> s_q.chain == 4'h1)
    else $error("chain stuck at zero");

endmodule

// ==== question_answer_watchdog.sv ====
// Notes on behaviour
// - Current 4-bit question is readable; host reads it before answering.
// - A cycle starts on the last answer byte or a response-delay write.
// - Each cycle is a programmable wait then a fixed window, then repeats.
// - Correct answer in window with nonzero delay decrements the fault tally.
// - Wrong, early, late answer or zero delay increments the fault tally.
// - Only the last byte's arrival is judged for timing.
// - Questions are deterministic; one repeats until answered right and on time.
// - The fault tally is three bits and chooses the protective actions.
// - Fault tally loads six after startup, reset and overflow.
// - Fault tally above four raises the internal alarm.
// - Overflow past seven requests a system reset only when enabled.
// - Any system reset event drives the alarm pin low.
// - Reset tally counts watchdog resets; at seven no more are issued.
// - Overflow bumps the abort tally; at seven another overflow aborts after-run.
// - Abort tally clears only with alarm low, or on undervoltage reset.
// - Result and next question are readable after the last answer byte.
// - Question counter advances only after a right, timely answer.
// - Markov chain steps on counter wrap after a right, timely answer.
// - Delay writes and window expiry leave counter and chain alone.
// - Undervoltage reset zeroes question counter and chain.
// - Chain feedback is top-bit XOR plus a path leaving all zeros.
// - Question bits mix chain and counter bits in a fixed order.
// - Two-bit byte index from 3 picks expected byte, steps down, kicks.
// - Expected bits are XORs of question bits and index bits.
// - Without enable no reset; with it, resets only while tally is 0..6.
// - Reset flag records a watchdog reset and clears when read.
`timescale 1ns/10ps
module question_answer_watchdog #(
  parameter logic [23:0] WINDOW_TICKS     = 24'h000040,
  parameter logic [15:0] DELAY_UNIT_TICKS = 16'h0040
) (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       answer_write,
  input  wire logic [7:0] answer_data,
  input  wire logic       delay_write,
  input  wire logic [7:0] delay_data,
  input  wire logic       flag_read,
  input  wire logic       reset_on_overflow_en,
  input  wire logic       ext_reset_pin,
  output logic [7:0]      question_low_reg,
  output logic [7:0]      question_high_reg,
  output logic [7:0]      response_delay_reg,
  output logic [1:0]      answer_byte_index,
  output logic [2:0]      fault_tally,
  output logic [2:0]      reset_tally,
  output logic [2:0]      afterrun_abort_tally,
  output logic            alarm_internal,
  output logic            afterrun_abort,
  output logic            monitor_reset_req,
  output logic            monitor_reset_flag,
  output logic            qa_alarm_pin_out,
  output logic            qa_alarm_pin_oe_n
);

  typedef struct packed {
    qa_wdg_pkg::phase_t phase;
    logic [23:0]        timer;
    logic [1:0]         index;
    logic               mismatch;
    logic [7:0]         delay;
    logic [2:0]         fault;
    logic [2:0]         rst_tally;
    logic [2:0]         ab_tally;
    logic               abort;
    logic               alarm;
    logic               req;
    logic               flag;
    logic               bad_value;
    logic               late;
    logic               advance;
    logic [3:0]         question;
    logic [2:0]         ev_sync;
    logic               ev_level;
    logic               oe_n;
    logic               pin_out;
  } wd_st_t;

  localparam wd_st_t RESET_ST = '{
    phase:     qa_wdg_pkg::PH_WAIT,
    timer:     24'h000000,
    index:     qa_wdg_pkg::INDEX_INIT,
    mismatch:  1'b0,
    delay:     8'h00,
    fault:     qa_wdg_pkg::FAULT_INIT,
    rst_tally: 3'h0,
    ab_tally:  3'h0,
    abort:     1'b0,
    alarm:     1'b1,
    req:       1'b0,
    flag:      1'b0,
    bad_value: 1'b0,
    late:      1'b0,
    advance:   1'b0,
    question:  4'h0,
    ev_sync:   3'h0,
    ev_level:  1'b0,
    oe_n:      1'b0,
    pin_out:   1'b0
  };

  wd_st_t     s_q;
  wd_st_t     s_d;
  logic       tick;
  logic [7:0] expected;
  logic       byte_diff;
  logic       kick;
  logic       expiry;
  logic       restart;
  logic       good;
  logic       err;
  logic       overflow;
  logic       ev_rise;

  qa_link_if lk ();

  slow_tick_gen u_tick (
    .mclk      (mclk),
    .resetn    (resetn),
    .slow_tick (tick)
  );

  question_gen u_question (
    .mclk   (mclk),
    .resetn (resetn),
    .lk     (lk.gen)
  );

  function automatic logic [7:0] expect_byte(input logic [3:0] q, input logic [1:0] i);
    logic [7:0] e;
    e[7] = q[2] ^ i[0];
    e[6] = q[0] ^ i[0];
    e[5] = q[3] ^ i[0];
    e[4] = q[1] ^ i[0];
    e[3] = q[2] ^ q[0] ^ q[3] ^ i[1];
    e[2] = q[0] ^ q[3] ^ q[1] ^ i[1];
    e[1] = q[2] ^ q[0] ^ q[1] ^ i[1];
    e[0] = i[1] ^ q[3] ^ q[0];
    return e;
  endfunction

  always_comb begin
    s_d         = s_q;
    s_d.advance = 1'b0;
    s_d.req     = 1'b0;
    good        = 1'b0;
    err         = 1'b0;
    overflow    = 1'b0;

    s_d.ev_sync = {s_q.ev_sync[1:0], ext_reset_pin};
    if (s_q.ev_sync[1] == s_q.ev_sync[2]) begin
      s_d.ev_level = s_q.ev_sync[2];
    end
    ev_rise = (s_q.ev_sync[1] == s_q.ev_sync[2]) && s_q.ev_sync[2] && !s_q.ev_level;

    expected  = expect_byte(lk.question, s_q.index);
    byte_diff = answer_data != expected;
    kick      = answer_write && (s_q.index == qa_wdg_pkg::INDEX_LAST);
    expiry    = tick && (s_q.timer == 24'h000000) && (s_q.phase == qa_wdg_pkg::PH_WIN);
    restart   = kick || delay_write || expiry;

    if (delay_write) begin
      s_d.delay = delay_data;
    end

    if (answer_write) begin
      s_d.index    = s_q.index - 2'h1;
      s_d.mismatch = s_q.mismatch || byte_diff;
    end

    if (tick) begin
      if (s_q.timer != 24'h000000) begin
        s_d.timer = s_q.timer - 24'h000001;
      end else if (s_q.phase == qa_wdg_pkg::PH_WAIT) begin
        s_d.phase = qa_wdg_pkg::PH_WIN;
        s_d.timer = WINDOW_TICKS - 24'h000001;
      end
    end

    if (restart) begin
      s_d.phase    = qa_wdg_pkg::PH_WAIT;
      s_d.timer    = 24'(delay_write ? delay_data : s_q.delay) * 24'(DELAY_UNIT_TICKS);
      s_d.index    = qa_wdg_pkg::INDEX_INIT;
      s_d.mismatch = 1'b0;
    end

    // only the last byte is timed
    if (kick) begin
      good          = !(s_q.mismatch || byte_diff) && (s_q.phase == qa_wdg_pkg::PH_WIN)
                      && (s_q.delay != 8'h00);
      // every other answer is an error
      err           = !good;
      s_d.bad_value = s_q.mismatch || byte_diff;
      s_d.late      = s_q.phase != qa_wdg_pkg::PH_WIN;
      // advance only after a good answer
      s_d.advance   = good;
    end else if (expiry) begin
      err      = 1'b1;
      s_d.late = 1'b1;
    end

    // abort tally clears with alarm low
    if (!s_q.alarm) begin
      s_d.ab_tally = 3'h0;
      s_d.abort    = 1'b0;
    end

    if (ev_rise) begin
      s_d.fault = qa_wdg_pkg::FAULT_INIT;
    end else if (err) begin
      if (s_q.fault == qa_wdg_pkg::TALLY_MAX) begin
        overflow  = 1'b1;
        s_d.fault = qa_wdg_pkg::FAULT_INIT;
      end else begin
        s_d.fault = s_q.fault + 3'h1;
      end
    end else if (good && s_q.fault != 3'h0) begin
      s_d.fault = s_q.fault - 3'h1;
    end

    if (overflow) begin
      if (s_q.ab_tally == qa_wdg_pkg::TALLY_MAX) begin
        s_d.abort = 1'b1;
      end else begin
        s_d.ab_tally = s_q.ab_tally + 3'h1;
      end
      if (reset_on_overflow_en && s_q.rst_tally != qa_wdg_pkg::TALLY_MAX) begin
        s_d.req       = 1'b1;
        s_d.rst_tally = s_q.rst_tally + 3'h1;
      end
    end

    // read clears, a new reset wins
    if (flag_read) begin
      s_d.flag = 1'b0;
    end
    if (s_d.req) begin
      s_d.flag = 1'b1;
    end

    s_d.alarm    = s_d.fault > qa_wdg_pkg::ALARM_ABOVE;
    // pin pulled low on alarm or reset
    s_d.oe_n     = !(s_d.alarm || s_d.req || s_d.ev_level);
    s_d.pin_out  = 1'b0;
    s_d.question = lk.question;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s_q <= RESET_ST;
    end else begin
      s_q <= s_d;
    end
  end

  assign lk.advance = s_q.advance;

  assign question_low_reg     = {4'h0, s_q.question};
  assign question_high_reg    = {1'b0, s_q.fault, 2'h0, s_q.late, s_q.bad_value};
  assign response_delay_reg   = s_q.delay;
  assign answer_byte_index    = s_q.index;
  assign fault_tally          = s_q.fault;
  assign reset_tally          = s_q.rst_tally;
  assign afterrun_abort_tally = s_q.ab_tally;
  assign alarm_internal       = s_q.alarm;
  assign afterrun_abort       = s_q.abort;
  assign monitor_reset_req    = s_q.req;
  assign monitor_reset_flag   = s_q.flag;
  assign qa_alarm_pin_out     = s_q.pin_out;
  assign qa_alarm_pin_oe_n    = s_q.oe_n;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence last_byte_s;
    answer_write && s_q.index == 2'h0 && !ev_rise;
  endsequence

  sequence good_answer_s;
    last_byte_s ##0 (!byte_diff && !s_q.mismatch && s_q.phase == qa_wdg_pkg::PH_WIN
                     && s_q.delay != 8'h00);
  endsequence

  sequence overflow_s;
    err && !ev_rise && s_q.fault == 3'h7;
  endsequence

  cycle_restart_a: assert property (last_byte_s |=> s_q.phase == qa_wdg_pkg::PH_WAIT
                                    && s_q.index == 2'h3)
    else $error("cycle not restarted by last answer byte");
  fault_dec_a: assert property (good_answer_s ##0 s_q.fault != 3'h0
                                |=> s_q.fault == $past(s_q.fault) - 3'h1)
    else $error("good answer did not lower fault tally");
  early_inc_a: assert property (last_byte_s ##0 s_q.phase == qa_wdg_pkg::PH_WAIT
                                ##0 s_q.fault < 3'h7
                                |=> s_q.fault == $past(s_q.fault) + 3'h1)
    else $error("early answer did not raise fault tally");
  alarm_level_a: assert property (s_q.alarm == (s_q.fault > 3'h4))
    else $error("alarm does not match fault tally");
  reset_gate_a: assert property (overflow_s ##0 !reset_on_overflow_en |=> !s_q.req)
    else $error("reset issued while disabled");
  reset_limit_a: assert property (s_q.rst_tally == 3'h7 |=> s_q.rst_tally == 3'h7 && !s_q.req)
    else $error("reset tally left seven");
  flag_clear_a: assert property (flag_read && !s_d.req |=> !s_q.flag)
    else $error("reset flag not cleared by read");
  abort_clear_a: assert property (!s_q.alarm |=> s_q.ab_tally == 3'h0 && !s_q.abort)
    else $error("abort tally not cleared with alarm low");
  pin_on_reset_a: assert property (s_q.req |-> !s_q.oe_n && !s_q.pin_out)
    else $error("alarm pin released during reset");
  overflow_load_a: assert property (overflow_s |=> s_q.fault == 3'h6 ##1 s_q.alarm)
    else $error("overflow did not reload fault tally");

endmodule

// ==== host_model.sv ====
`timescale 1ns/10ps
module host_model (
  input  wire logic        mclk,
  input  wire logic        go,
  input  wire logic [15:0] gap,
  input  wire logic [1:0]  bad_idx,
  input  wire logic [7:0]  bad_mask,
  input  wire logic [7:0]  question_low_reg,
  output logic             answer_write,
  output logic [7:0]       answer_data,
  output logic             busy
);
  function automatic logic [7:0] expect_byte(logic [3:0] q, logic [1:0] i);
    return {q[2] ^ i[0], q[0] ^ i[0], q[3] ^ i[0], q[1] ^ i[0],
            q[2] ^ q[0] ^ q[3] ^ i[1], q[0] ^ q[3] ^ q[1] ^ i[1],
            q[2] ^ q[0] ^ q[1] ^ i[1], i[1] ^ q[3] ^ q[0]};
  endfunction

  initial begin
    answer_write = 1'b0;
    answer_data  = 8'h00;
    busy         = 1'b0;
    forever begin
      @(posedge mclk);
      if (go === 1'b1) begin
        #1 busy = 1'b1;
        for (int i = 3; i >= 0; i--) begin
          if (i == 0 && gap != 16'h0000) begin
            answer_write = 1'b0;
            answer_data  = ~answer_data;
            repeat (gap) @(posedge mclk);
            #1;
          end
          answer_data  = expect_byte(question_low_reg[3:0], 2'(i))
                         ^ ((2'(i) == bad_idx) ? bad_mask : 8'h00);
          answer_write = 1'b1;
          @(posedge mclk);
          #1;
        end
        answer_write = 1'b0;
        answer_data  = ~answer_data;
        busy         = 1'b0;
      end
    end
  end
endmodule

// ==== testbench.sv ====
`timescale 1ns/10ps
module testbench;
  logic        mclk = 1'b0, resetn = 1'b0, go = 1'b0, delay_write = 1'b0, flag_read = 1'b0;
  logic        reset_on_overflow_en = 1'b0, ext_reset_pin = 1'b0;
  logic [15:0] gap = 16'h0000;
  logic [1:0]  bad_idx = 2'h0;
  logic [7:0]  bad_mask = 8'h00, delay_data = 8'h00;
  logic        answer_write, busy, alarm_internal, afterrun_abort, monitor_reset_req;
  logic        monitor_reset_flag, qa_alarm_pin_out, qa_alarm_pin_oe_n;
  logic [7:0]  answer_data, question_low_reg, question_high_reg, response_delay_reg;
  logic [1:0]  answer_byte_index;
  logic [2:0]  fault_tally, reset_tally, afterrun_abort_tally;
  int          num_errors = 0, comparisons = 0, cycles = 0, pulses = 0;
  int          flt = 6, z = 0, rst = 0, ab = 0, abort_m = 0, flag_m = 0;
  integer      seed = 32'h0CDC;

  question_answer_watchdog #(.WINDOW_TICKS(24'h000004), .DELAY_UNIT_TICKS(16'h0002)) u_dut (
    .mclk(mclk), .resetn(resetn), .answer_write(answer_write), .answer_data(answer_data),
    .delay_write(delay_write), .delay_data(delay_data), .flag_read(flag_read),
    .reset_on_overflow_en(reset_on_overflow_en), .ext_reset_pin(ext_reset_pin),
    .question_low_reg(question_low_reg), .question_high_reg(question_high_reg),
    .response_delay_reg(response_delay_reg), .answer_byte_index(answer_byte_index),
    .fault_tally(fault_tally), .reset_tally(reset_tally),
    .afterrun_abort_tally(afterrun_abort_tally), .alarm_internal(alarm_internal),
    .afterrun_abort(afterrun_abort), .monitor_reset_req(monitor_reset_req),
    .monitor_reset_flag(monitor_reset_flag), .qa_alarm_pin_out(qa_alarm_pin_out),
    .qa_alarm_pin_oe_n(qa_alarm_pin_oe_n));

  host_model u_host (
    .mclk(mclk), .go(go), .gap(gap), .bad_idx(bad_idx), .bad_mask(bad_mask),
    .question_low_reg(question_low_reg), .answer_write(answer_write),
    .answer_data(answer_data), .busy(busy));

  always #5 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (monitor_reset_req === 1'b1)
      pulses++;
    if (cycles == 80000) begin
      num_errors++;
      end_sim();
    end
  end

  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic int win();
    return 5300 + int'({$random(seed)} % 200);
  endfunction

  task model_chk;
    logic al;
    al = flt > 4;
    chk(8'(fault_tally), 8'(flt));
    chk(question_low_reg, {4'h0, z[2], z[0], z[3], z[1]});
    chk(8'(alarm_internal), 8'(al));
    chk(8'(qa_alarm_pin_oe_n), 8'(!al));
    chk(8'(reset_tally), 8'(rst));
    chk(8'(afterrun_abort_tally), 8'(ab));
    chk(8'(afterrun_abort), 8'(abort_m));
    chk(8'(monitor_reset_flag), 8'(flag_m));
    chk(8'(pulses), 8'(rst));
  endtask

  task judge(bit good);
    if (good) begin
      flt = (flt > 0) ? flt - 1 : 0;
      z = (z + 1) % 16;
    end else if (flt == 7) begin
      flt = 6;
      if (reset_on_overflow_en === 1'b1 && rst < 7) begin
        rst++;
        flag_m = 1;
      end
      if (ab == 7)
        abort_m = 1;
      else
        ab++;
    end else
      flt++;
    if (flt < 5) begin
      ab = 0;
      abort_m = 0;
    end
    model_chk();
  endtask

  task answer(int g, bit bad, bit good, int hi);
    gap = 16'(g);
    bad_mask = bad ? (8'($random(seed)) | 8'h01) : 8'h00;
    bad_idx = 2'($random(seed));
    go = 1'b1;
    @(posedge mclk);
    #1 go = 1'b0;
    if (g > 20) begin
      repeat (10) @(posedge mclk);
      chk(8'(answer_byte_index), 8'h00);
    end
    for (int i = 0; i < g + 20 && busy !== 1'b0; i++) @(posedge mclk);
    repeat (5) @(posedge mclk);
    #1;
    chk(8'(answer_byte_index), 8'h03);
    judge(good);
    if (hi >= 0)
      chk(question_high_reg, {1'b0, 3'(flt), 2'b00, 2'(hi)});
    $display("test end: answer gap %0d", g);
  endtask

  task set_delay(logic [7:0] d);
    delay_data = d;
    delay_write = 1'b1;
    @(posedge mclk);
    #1 delay_write = 1'b0;
    @(posedge mclk);
    #1;
    chk(response_delay_reg, d);
    chk(8'(answer_byte_index), 8'h03);
    $display("test end: delay %h", d);
  endtask

  initial begin
    logic [2:0] old;
    repeat (16) @(posedge mclk);
    #1 resetn = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    model_chk();
    chk(8'(qa_alarm_pin_out), 8'h00);
    $display("test end: reset");
    set_delay(8'h01);
    answer(0, 0, 0, 2);
    answer(0, 1, 0, -1);
    reset_on_overflow_en = 1'b1;
    answer(win(), 0, 1, 0);
    answer(win(), 0, 1, 0);
    ext_reset_pin = 1'b1;
    repeat (8) @(posedge mclk);
    #1 flt = 6;
    model_chk();
    ext_reset_pin = 1'b0;
    $display("test end: external reset");
    set_delay(8'h01);
    answer(win(), 1, 0, 1);
    answer(0, 1, 0, -1);
    flag_read = 1'b1;
    @(posedge mclk);
    #1 flag_read = 1'b0;
    flag_m = 0;
    @(posedge mclk);
    #1 model_chk();
    $display("test end: flag read");
    answer(win(), 0, 1, 0);
    set_delay(8'h00);
    answer(2000, 0, 0, -1);
    set_delay(8'h01);
    old = fault_tally;
    for (int i = 0; i < 15000 && fault_tally === old; i++) @(posedge mclk);
    repeat (2) @(posedge mclk);
    #1 judge(0);
    $display("test end: window expiry");
    // Repeated early wrong answers drive the reset and abort tallies to their limits
    for (int k = 0; k < 16; k++)
      answer(0, 1, 0, 3);
    $display("test end: tally limits");
    end_sim();
  end
endmodule
